/* File: hw/lphc_top.sv */
// lphc_top: gain, range, hysteresis and persistence settings with apb access
`timescale 1ns/10ps
module lphc_top #(
  parameter int unsigned AW = 12
) (
  // apb
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [AW-1:0]         paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic      [31:0]           prdata,
  output logic                       pslverr,
  // visible conversion control
  input  wire logic                  vis_meas_start,
  input  wire logic [2:0]            vis_rec_sel,
  output logic                       vis_adc_en,
  output logic      [2:0]            vis_scale,
  output logic                       vis_high_range,
  output logic                       vis_rec_busy,
  output logic                       vis_rec_done,
  // infrared ambient settings
  input  wire logic                  early_rev,
  input  wire logic [2:0]            ir_scale_in,
  input  wire logic                  ir_span_in,
  output logic      [2:0]            ir_scale,
  output logic                       ir_high_range,
  // ambient threshold evaluation
  input  wire logic                  amb_valid,
  input  wire logic [15:0]           amb_sample,
  input  wire logic [15:0]           ambient_lower_threshold,
  input  wire logic [15:0]           ambient_upper_threshold,
  output logic                       amb_above,
  output logic                       amb_below,
  // proximity threshold evaluation
  input  wire logic [2:0]            ps_valid,
  input  wire logic [2:0][15:0]      ps_sample,
  input  wire logic [2:0][15:0]      ps_threshold,
  output logic      [2:0]            ps_near,
  // interrupt
  output logic                       irq
);

  // ===========================================================================
  // state
  typedef struct packed {
    logic [2:0]                 scale;
    logic                       span;
    logic [7:0]                 amb_hyst;
    logic [7:0]                 proximity_hysteresis;
    logic [7:0]                 persist;
    logic [lphc_pkg::IRQ_W-1:0] irq_stat;
    logic [lphc_pkg::IRQ_W-1:0] irq_mask;
    logic [2:0]                 base_cnt;
    logic [6:0]                 div_cnt;
    logic                       vis_tick;
    lphc_pkg::lphc_rec_e        rec_st;
    logic [8:0]                 rec_cnt;
    logic                       rec_done;
    logic [2:0]                 near;
    logic [2:0][7:0]            hist;
    logic                       amb_hi;
    logic                       amb_lo;
    logic [2:0]                 ir_scale;
    logic                       ir_span;
    logic [31:0]                prdata;
    logic                       pslverr;
  } lphc_state_s;

  localparam lphc_state_s RST_S = '{
    scale:    lphc_pkg::RST_VIS_INT[2:0],
    span:     lphc_pkg::RST_VIS_RNG[lphc_pkg::SPAN_BIT],
    amb_hyst: lphc_pkg::RST_HYST,
    proximity_hysteresis:  lphc_pkg::RST_HYST,
    persist:  lphc_pkg::RST_PERSIST,
    rec_st:   lphc_pkg::REC_IDLE,
    default:  '0
  };

  localparam logic [2:0] BASE_LAST = 3'(lphc_pkg::ADC_BASE_CYC - 1);

  lphc_state_s s_q;
  lphc_state_s s_d;
  logic [15:0] amb_hyst_x;
  logic [15:0] proximity_hysteresis_x;

  // ===========================================================================
  // address decode
  function automatic logic lphc_mapped(input logic [AW-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    lphc_mapped = (a[1:0] == 2'h0) && (a[AW-1:10] == '0) &&
                  (i == lphc_pkg::IDX_VIS_INT  || i == lphc_pkg::IDX_VIS_RNG  ||
                   i == lphc_pkg::IDX_AMB_HYST || i == lphc_pkg::IDX_PROXIMITY_HYSTERESIS  ||
                   i == lphc_pkg::IDX_PERSIST  || i == lphc_pkg::IDX_IRQ_STAT ||
                   i == lphc_pkg::IDX_IRQ_MASK || i == lphc_pkg::IDX_STATUS);
  endfunction

  // ===========================================================================
  // hysteresis expansion
  lphc_expand u_amb_exp (
    .code  (s_q.amb_hyst),
    .value (amb_hyst_x)
  );

  lphc_expand u_ps_exp (
    .code  (s_q.proximity_hysteresis),
    .value (proximity_hysteresis_x)
  );

  // ===========================================================================
  // next state
  always_comb begin
    logic [7:0]                 idx;
    logic                       acc;
    logic [lphc_pkg::IRQ_W-1:0] ev;
    logic [lphc_pkg::IRQ_W-1:0] clr;
    logic                       qual;
    logic [7:0]                 h;
    idx  = paddr[9:2];
    acc  = psel && penable;
    ev   = '0;
    clr  = '0;
    qual = 1'b0;
    h    = '0;
    s_d  = s_q;

    // apb read data captured in setup, presented in access
    if (psel && !penable) begin
      s_d.prdata  = '0;
      s_d.pslverr = !lphc_mapped(paddr);
      if (lphc_mapped(paddr)) begin
        unique case (idx)
          lphc_pkg::IDX_VIS_INT:  s_d.prdata[2:0] = s_q.scale;
          lphc_pkg::IDX_VIS_RNG:  s_d.prdata[lphc_pkg::SPAN_BIT] = s_q.span;
          lphc_pkg::IDX_AMB_HYST: s_d.prdata[7:0] = s_q.amb_hyst;
          lphc_pkg::IDX_PROXIMITY_HYSTERESIS:  s_d.prdata[7:0] = s_q.proximity_hysteresis;
          lphc_pkg::IDX_PERSIST:  s_d.prdata[7:0] = s_q.persist;
          lphc_pkg::IDX_IRQ_STAT: s_d.prdata[lphc_pkg::IRQ_W-1:0] = s_q.irq_stat;
          lphc_pkg::IDX_IRQ_MASK: s_d.prdata[lphc_pkg::IRQ_W-1:0] = s_q.irq_mask;
          default:                s_d.prdata[4:0] = {s_q.near, s_q.amb_lo, s_q.amb_hi};
        endcase
      end
    end

    // apb write, reserved bits dropped
    if (acc && pwrite && lphc_mapped(paddr)) begin
      unique case (idx)
        lphc_pkg::IDX_VIS_INT:  s_d.scale = pwdata[2:0];
        lphc_pkg::IDX_VIS_RNG:  s_d.span = pwdata[lphc_pkg::SPAN_BIT];
        lphc_pkg::IDX_AMB_HYST: s_d.amb_hyst = pwdata[7:0];
        lphc_pkg::IDX_PROXIMITY_HYSTERESIS:  s_d.proximity_hysteresis = pwdata[7:0];
        lphc_pkg::IDX_PERSIST:  s_d.persist = pwdata[7:0];
        lphc_pkg::IDX_IRQ_STAT: clr = pwdata[lphc_pkg::IRQ_W-1:0];
        lphc_pkg::IDX_IRQ_MASK: s_d.irq_mask = pwdata[lphc_pkg::IRQ_W-1:0];
        default:                s_d.irq_mask = s_q.irq_mask;
      endcase
    end

    // adc clock: base 50 ns tick divided by 2^scale
    s_d.vis_tick = 1'b0;
    if (s_q.base_cnt == BASE_LAST) begin
      s_d.base_cnt = '0;
      if (s_q.div_cnt >= lphc_pkg::lphc_div_last(s_q.scale)) begin
        s_d.div_cnt  = '0;
        s_d.vis_tick = 1'b1;
      end else begin
        s_d.div_cnt = s_q.div_cnt + 7'h01;
      end
    end else begin
      s_d.base_cnt = s_q.base_cnt + 3'h1;
    end

    // recovery delay counted in scaled adc clocks
    s_d.rec_done = 1'b0;
    unique case (s_q.rec_st)
      lphc_pkg::REC_IDLE: begin
        if (vis_meas_start) begin
          s_d.rec_cnt = lphc_pkg::lphc_rec_len(vis_rec_sel);
          s_d.rec_st  = lphc_pkg::REC_RUN;
        end
      end
      lphc_pkg::REC_RUN: begin
        if (s_q.vis_tick) begin
          if (s_q.rec_cnt == 9'h001) begin
            s_d.rec_done = 1'b1;
            s_d.rec_st   = lphc_pkg::REC_IDLE;
          end else begin
            s_d.rec_cnt = s_q.rec_cnt - 9'h001;
          end
        end
      end
    endcase

    // infrared settings follow visible ones on early revisions
    s_d.ir_scale = early_rev ? s_q.scale : ir_scale_in;
    s_d.ir_span  = early_rev ? s_q.span : ir_span_in;

    // ambient crossings with hysteresis on both thresholds
    if (amb_valid) begin
      s_d.amb_hi = {1'b0, amb_sample} >
                   ({1'b0, ambient_upper_threshold} + {1'b0, amb_hyst_x});
      s_d.amb_lo = ({1'b0, amb_sample} + {1'b0, amb_hyst_x}) <
                   {1'b0, ambient_lower_threshold};
      ev[lphc_pkg::IRQ_AMB_HI] = s_d.amb_hi && !s_q.amb_hi;
      ev[lphc_pkg::IRQ_AMB_LO] = s_d.amb_lo && !s_q.amb_lo;
    end

    // proximity persistence per channel
    for (int i = 0; i < 3; i++) begin
      if (ps_valid[i]) begin
        if (s_q.near[i]) begin
          qual = ({1'b0, ps_sample[i]} + {1'b0, proximity_hysteresis_x}) <
                 {1'b0, ps_threshold[i]};
        end else begin
          qual = {1'b0, ps_sample[i]} >
                 ({1'b0, ps_threshold[i]} + {1'b0, proximity_hysteresis_x});
        end
        h = {s_q.hist[i][6:0], qual};
        if (qual && ((h & s_q.persist) == s_q.persist)) begin
          s_d.near[i]                 = !s_q.near[i];
          s_d.hist[i]                 = '0;
          ev[lphc_pkg::IRQ_PS0 + i]   = 1'b1;
        end else begin
          s_d.hist[i] = h;
        end
      end
    end

    // sticky status, set wins over clear
    s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
  end

  // ===========================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= RST_S;
    end else begin
      s_q <= s_d;
    end
  end

  // ===========================================================================
  // outputs
  assign pready         = 1'b1;
  assign prdata         = s_q.prdata;
  assign pslverr        = s_q.pslverr;
  assign vis_adc_en     = s_q.vis_tick;
  assign vis_scale      = s_q.scale;
  assign vis_high_range = s_q.span;
  assign vis_rec_busy   = (s_q.rec_st == lphc_pkg::REC_RUN);
  assign vis_rec_done   = s_q.rec_done;
  assign ir_scale       = s_q.ir_scale;
  assign ir_high_range  = s_q.ir_span;
  assign amb_above      = s_q.amb_hi;
  assign amb_below      = s_q.amb_lo;
  assign ps_near        = s_q.near;
  assign irq            = |(s_q.irq_stat & s_q.irq_mask);

endmodule

/* File: inc/lphc_pkg.sv */
// lphc_pkg: shared constants for the light/proximity gain and hysteresis block
package lphc_pkg;

  // ===========================================================================
  // timing
  localparam int unsigned CLK_NS      = 10;
  localparam int unsigned ADC_BASE_NS = 50;
  localparam int unsigned ADC_BASE_CYC = (ADC_BASE_NS + CLK_NS - 1) / CLK_NS;

  // ===========================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_VIS_INT  = 8'h11;
  localparam logic [7:0] IDX_VIS_RNG  = 8'h12;
  localparam logic [7:0] IDX_AMB_HYST = 8'h16;
  localparam logic [7:0] IDX_PROXIMITY_HYSTERESIS  = 8'h17;
  localparam logic [7:0] IDX_PERSIST  = 8'h18;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] IDX_STATUS   = 8'h22;

  // ===========================================================================
  // fields and reset values
  localparam int unsigned SCALE_W   = 3;
  localparam int unsigned SPAN_BIT  = 5;
  localparam logic [2:0] MAX_SCALE  = 3'h7;
  localparam logic [7:0] RST_VIS_INT = 8'h00;
  localparam logic [7:0] RST_VIS_RNG = 8'h00;
  localparam logic [7:0] RST_HYST    = 8'h48;
  localparam logic [7:0] RST_PERSIST = 8'h03;

  // ===========================================================================
  // interrupt bits
  localparam int unsigned IRQ_W      = 5;
  localparam int unsigned IRQ_AMB_HI = 0;
  localparam int unsigned IRQ_AMB_LO = 1;
  localparam int unsigned IRQ_PS0    = 2;

  typedef enum logic {
    REC_IDLE = 1'b0,
    REC_RUN  = 1'b1
  } lphc_rec_e;

  // ===========================================================================
  // last count of the visible divider: 2^scale - 1
  function automatic logic [6:0] lphc_div_last(input logic [2:0] scale);
    lphc_div_last = 7'((8'h01 << scale) - 8'h01);
  endfunction

  // recovery length in visible adc clocks: 1, 7, 15 .. 511
  function automatic logic [8:0] lphc_rec_len(input logic [2:0] sel);
    if (sel == 3'h0) begin
      lphc_rec_len = 9'h001;
    end else begin
      lphc_rec_len = 9'((11'h004 << sel) - 11'h001);
    end
  endfunction

endpackage

/* File: hw/lphc_expand.sv */
// lphc_expand: expands an 8-bit compressed hysteresis code to 16 bits
`timescale 1ns/10ps
module lphc_expand (
  // compressed code
  input  wire logic [7:0]  code,
  // expanded magnitude
  output logic      [15:0] value
);

  // ===========================================================================
  // exponent in the high nibble, mantissa with hidden one in the low nibble
  logic [35:0] wide;

  always_comb begin
    wide  = 36'({1'b1, code[3:0]}) << code[7:4];
    value = wide[19:4];
  end

endmodule

/* File: bench/lphc_host.sv */
// lphc_host: apb host model for the settings registers
`timescale 1ns/10ps
module lphc_host (
  // clock
  input  wire logic        pclk,
  // request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  // answer
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // =========
  // one transfer: setup, access until pready, release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d; // reserved bits are zero except where a caller probes them
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* File: bench/lphc_top_asserts.sv */
// lphc_top_asserts: port-level properties of lphc_top
`timescale 1ns/10ps
module lphc_top_asserts (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // visible control
  input wire logic       vis_meas_start,
  input wire logic       vis_adc_en,
  input wire logic [2:0] vis_scale,
  input wire logic       vis_high_range,
  input wire logic       vis_rec_busy,
  input wire logic       vis_rec_done,
  // infrared
  input wire logic       early_rev,
  input wire logic [2:0] ir_scale_in,
  input wire logic       ir_span_in,
  input wire logic [2:0] ir_scale,
  input wire logic       ir_high_range,
  // evaluation
  input wire logic       amb_valid,
  input wire logic       amb_above,
  input wire logic       amb_below,
  input wire logic [2:0] ps_valid,
  input wire logic [2:0] ps_near,
  input wire logic       irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // =========
  // properties
  a_adc_gap: assert property (vis_adc_en |=> !vis_adc_en [*4])
    else $error("adc enable pulses too close");
  a_adc_base: assert property (vis_adc_en ##4 vis_scale == 3'h0 |=> vis_adc_en)
    else $error("scale 0 period wrong");
  a_done_idle: assert property (vis_rec_done |-> !vis_rec_busy ##1 !vis_rec_done)
    else $error("done not a single idle pulse");
  a_done_cause: assert property (vis_rec_done |-> $past(vis_adc_en) && $past(vis_rec_busy))
    else $error("done without adc clock");
  a_busy_start: assert property (vis_meas_start && !vis_rec_busy && !vis_rec_done
    |=> vis_rec_busy) else $error("start did not set busy");
  a_ir_copy: assert property (early_rev && $past(early_rev) && $stable(vis_scale) &&
    $stable(vis_high_range) |-> ir_scale == vis_scale && ir_high_range == vis_high_range)
    else $error("ir settings not copied");
  a_ir_own: assert property (!early_rev |=> ir_scale == $past(ir_scale_in) &&
    ir_high_range == $past(ir_span_in)) else $error("ir settings not own");
  a_amb_hold: assert property (!amb_valid |=> $stable(amb_above) && $stable(amb_below))
    else $error("ambient flags moved");
  a_near_hold: assert property (ps_valid == 3'h0 |=> $stable(ps_near))
    else $error("proximity status moved");

  c_done: cover property (vis_rec_done);
  c_near: cover property (ps_near == 3'h7);
  c_irq: cover property ($rose(irq));
endmodule

bind lphc_top lphc_top_asserts u_chk (.*);

/* File: bench/lphc_top_tb.sv */
// lphc_top_tb: self-checking bench for lphc_top
`timescale 1ns/10ps
module lphc_top_tb;
  // =========
  // signals
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  int               n_errors = 0;
  int               cmp_count = 0;
  int               cyc = 0;
  logic             psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rdat;
  logic             vis_meas_start = 1'b0;
  logic [2:0]       vis_rec_sel = 3'h0;
  logic             vis_adc_en, vis_high_range, vis_rec_busy, vis_rec_done;
  logic [2:0]       vis_scale, ir_scale;
  logic             early_rev = 1'b0;
  logic [2:0]       ir_scale_in = 3'h0;
  logic             ir_span_in = 1'b0;
  logic             amb_valid = 1'b0;
  logic [15:0]      amb_sample = 16'h0000;
  logic [15:0]      ambient_lower_threshold = 16'h0064;
  logic [15:0]      ambient_upper_threshold = 16'h03E8;
  logic             amb_above, amb_below, irq, ir_high_range;
  logic [2:0]       ps_valid = 3'h0;
  logic [2:0][15:0] ps_sample = '0;
  logic [2:0][15:0] ps_threshold = {3{16'h01F4}};
  logic [2:0]       ps_near;

  always #5 pclk = ~pclk;
  lphc_top dut (.*);
  lphc_host u_host (.*);

  // =========
  // helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    u_host.xfer(1'b1, {2'b00, idx, 2'b00}, d, rdat, rerr);
  endtask
  task automatic rd(input logic [7:0] idx);
    u_host.xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0, rdat, rerr);
  endtask
  task automatic wait_en;
    do @(negedge pclk); while (vis_adc_en !== 1'b1);
  endtask
  task automatic amb(input logic [15:0] s, input logic [1:0] e);
    @(posedge pclk);
    amb_sample <= s;
    amb_valid <= 1'b1;
    @(posedge pclk);
    amb_valid <= 1'b0;
    @(negedge pclk);
    chk("amb flags", {30'h0, e}, {30'h0, amb_below, amb_above});
  endtask
  task automatic ps(input int c, input logic [15:0] s);
    @(posedge pclk);
    ps_sample <= {3{s}};
    ps_valid <= 3'(1 << c);
    @(posedge pclk);
    ps_valid <= 3'h0;
    @(negedge pclk);
  endtask

  // =========
  // scenarios
  task automatic t_reset;
    logic [7:0] idx [5] = '{lphc_pkg::IDX_VIS_INT, lphc_pkg::IDX_VIS_RNG,
      lphc_pkg::IDX_AMB_HYST, lphc_pkg::IDX_PROXIMITY_HYSTERESIS, lphc_pkg::IDX_PERSIST};
    logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h48, 8'h48, 8'h03};
    for (int i = 0; i < 5; i++) begin
      rd(idx[i]);
      chk("reset", {24'h0, rv[i]}, rdat);
    end
    chk("scale rst", 32'h0, {28'h0, vis_high_range, vis_scale});
  endtask
  task automatic t_rw;
    wr(lphc_pkg::IDX_VIS_INT, 32'h0000_00FF);
    wr(lphc_pkg::IDX_VIS_RNG, 32'h0000_00FF);
    rd(lphc_pkg::IDX_VIS_INT);
    chk("scale rd", 32'h7, rdat);
    rd(lphc_pkg::IDX_VIS_RNG);
    chk("span rd", 32'h20, rdat);
    chk("vis out", 32'hF, {28'h0, vis_high_range, vis_scale});
    @(posedge pclk);
    early_rev <= 1'b1;
    ir_scale_in <= 3'h2;
    repeat (2) @(negedge pclk);
    chk("ir copy", 32'hF, {28'h0, ir_high_range, ir_scale});
    @(posedge pclk);
    early_rev <= 1'b0;
    repeat (2) @(negedge pclk);
    chk("ir own", 32'h2, {28'h0, ir_high_range, ir_scale});
    rd(8'h30);
    chk("unmapped", 32'h1, {31'h0, rerr});
    wr(lphc_pkg::IDX_VIS_RNG, 32'h0);
  endtask
  task automatic t_adc;
    logic [2:0] sc [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(lphc_pkg::IDX_VIS_INT, {29'h0, sc[i]});
      repeat (2) wait_en();
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (vis_adc_en !== 1'b1);
      chk("adc period", 32'(5 << sc[i]), 32'(n));
    end
    wr(lphc_pkg::IDX_VIS_INT, 32'h0);
  endtask
  task automatic t_rec;
    int ne [2] = '{1, 7};
    int n;
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      vis_rec_sel <= 3'(i);
      vis_meas_start <= 1'b1;
      @(posedge pclk);
      vis_meas_start <= 1'b0;
      @(negedge pclk);
      chk("busy", 32'h1, {31'h0, vis_rec_busy});
      n = 0;
      while (vis_rec_done !== 1'b1) begin
        if (vis_adc_en === 1'b1) n++;
        @(negedge pclk);
      end
      chk("rec clocks", ne[i], n);
    end
  endtask
  task automatic t_amb;
    wr(lphc_pkg::IDX_IRQ_MASK, 32'h3);
    amb(16'h0400, 2'b00);
    chk("irq off", 32'h0, {31'h0, irq});
    amb(16'h0401, 2'b01);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(lphc_pkg::IDX_IRQ_STAT, 32'h3);
    @(negedge pclk);
    chk("irq clr", 32'h0, {31'h0, irq});
    amb(16'h004B, 2'b10);
    wr(lphc_pkg::IDX_IRQ_MASK, 32'h0);
    @(negedge pclk);
    chk("irq mask", 32'h0, {31'h0, irq});
    rd(lphc_pkg::IDX_IRQ_STAT);
    chk("irq stat", 32'h2, rdat);
    amb(16'h004C, 2'b00);
    wr(lphc_pkg::IDX_IRQ_STAT, 32'h1F);
    wr(lphc_pkg::IDX_IRQ_MASK, 32'h1C);
  endtask
  task automatic t_ps;
    logic [7:0] mk [3] = '{8'h03, 8'h07, 8'hFF};
    int k [3] = '{2, 3, 8};
    logic [2:0] nr = 3'h0;
    for (int c = 0; c < 3; c++) begin
      if (c > 0) wr(lphc_pkg::IDX_PERSIST, {24'h0, mk[c]});
      ps(c, 16'h020C);
      for (int j = 1; j < k[c]; j++) ps(c, 16'h020D);
      chk("near early", {29'h0, nr}, {29'h0, ps_near});
      ps(c, 16'h020D);
      nr[c] = 1'b1;
      chk("near", {29'h0, nr}, {29'h0, ps_near});
    end
    rd(lphc_pkg::IDX_IRQ_STAT);
    chk("ps stat", 32'h1C, rdat);
    chk("ps irq", 32'h1, {31'h0, irq});
    wr(lphc_pkg::IDX_PERSIST, 32'h0000_0003);
    ps(0, 16'h01DC);
    ps(0, 16'h01DB);
    chk("near hold", 32'h7, {29'h0, ps_near});
    ps(0, 16'h01DB);
    chk("near off", 32'h6, {29'h0, ps_near});
    rd(lphc_pkg::IDX_STATUS);
    chk("status", 32'h18, rdat);
  endtask

  // =========
  // verdict, watchdog and sequence
  task automatic results;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rw();
    t_adc();
    t_rec();
    t_amb();
    t_ps();
    results();
  end
endmodule
